/* spm_checker.sv */
// Port-level assertions for the serial master, bound to every instance
`timescale 1ns/100ps
module spm_checker
	import spm_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Serial side
	input wire spm_serial_t serial_out,
	input wire logic [3:0]  host_irq_lines
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack late");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

	property p_dat_upper;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_dat_upper: assert property (p_dat_upper) else $error("upper read bits set");

	property p_irq_quiet;
		host_irq_lines == 4'h0;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("host line raised");

	property p_one_select;
		serial_out.select_out_first_n || serial_out.select_out_second_n;
	endproperty
	a_one_select: assert property (p_one_select) else $error("both selects low");

	// Fastest rate holds each level seven cycles
	property p_sclk_level;
		$changed(serial_out.sclk) |=> $stable(serial_out.sclk) [*6];
	endproperty
	a_sclk_level: assert property (p_sclk_level) else $error("sclk level short");

	property p_reset_idle;
		$rose(nrst) |-> !wb_ack_o && !serial_out.sclk && serial_out.select_out_first_n
			&& serial_out.select_out_second_n;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle at reset");
endmodule // spm_checker

bind spm_master spm_checker u_spm_checker (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_out(serial_out),
	.host_irq_lines(host_irq_lines));

/* spm_master.sv */
// Byte-register serial peripheral master with classic Wishbone slave port
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "spm_regs.svh"

// What this block does
// - Serial clock idles low with polarity bit 0, high with bit 1.
// - Phase bit 0 samples on rising edge, 1 samples on falling edge.
// - Frame length codes 00..11 give 8, 16, 24, 32 bits, any select mode.
// - Auto mode asserts chosen select on start; manual mode follows select field.
// - Select code 000 none, 001 first, 010 second; others assert nothing.
// - Rate codes 00..11 divide the 33 MHz reference by 32, 16, 8, 4.
// - Low-bit-first 0 shifts left MSB first; 1 shifts right LSB first.
// - MSB first: send bit 31 first, receive into bit 0.
// - LSB first: send bit 0 first, receive into bit 31.
// - Writing data byte 3 starts clock, transfer and auto select.
// - Four data bytes hold the frame, byte 0 lowest, byte 3 highest.
// - Busy status reads 1 while shifting and 0 when idle.
// - Interrupt flag mirrors the active-low external interrupt input.
// - With enable set, the external interrupt drives the selected host line.
// - Interrupt select 00..11 routes to host line 3, 4, 5, 10.
// - External interrupt unconnected here: host lines stay low, fields still RW.
// - Exactly two slave select outputs exist.
// - Loopback bit feeds serial output back to input, output still driven.
module spm_master #(
	parameter int ADR_W             = 6,
	parameter bit EXT_IRQ_CONNECTED = 1'b0
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// Wishbone slave
	input  wire logic [ADR_W-1:0]     wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic                 wb_we_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Expansion serial bus
	output spm_pkg::spm_serial_t      serial_out,
	input  wire logic                 serial_data_in,
	input  wire logic                 ext_irq_in_n,
	// Host interrupt lines 3, 4, 5, 10
	output logic      [3:0]           host_irq_lines
);
	import spm_pkg::*;

	localparam int HALF_MAX = (`SPM_SLOWEST_DIV * `SPM_MCLK_KHZ) / (2 * `SPM_REF_CLK_KHZ);
	localparam int CNT_W    = $clog2(HALF_MAX + 1);

	spm_control_t            control_reg;
	spm_status_t             status_reg;
	logic                    loopback_reg;
	logic                    ext_flag_reg;
	logic [31:0]             shift_reg;
	spm_state_t              state_reg;
	logic [CNT_W-1:0]        div_reg;
	logic [6:0]              edge_reg;
	logic                    sampled_reg;
	logic                    sclk_reg;
	logic                    mosi_reg;
	logic [1:0]              select_reg;
	logic [3:0]              irq_reg;

	logic                    access;
	logic                    wr_en;
	logic [3:0]              idx;
	logic [7:0]              wr_byte;
	logic                    start;
	logic                    busy;
	logic [CNT_W-1:0]        half_cnt;
	logic [6:0]              last_edge;
	logic                    edge_tick;
	logic                    sample_edge;
	logic                    rx_bit;

	// Half period in mclk cycles, rounded down, at least one
	function automatic logic [CNT_W-1:0] half_period(input logic [1:0] rate);
		int div;
		int cyc;
		div = `SPM_SLOWEST_DIV >> rate;
		cyc = (div * `SPM_MCLK_KHZ) / (2 * `SPM_REF_CLK_KHZ);
		if (cyc < 1) begin
			cyc = 1;
		end
		return CNT_W'(cyc);
	endfunction

	// Only codes 001 and 010 name a device
	function automatic logic [1:0] select_decode(input logic [2:0] code);
		case (code)
			3'h1:    return 2'b01;
			3'h2:    return 2'b10;
			default: return 2'b00;
		endcase
	endfunction

	assign idx       = wb_adr_i[5:2];
	assign wr_byte   = wb_dat_i[7:0];
	// Write lands on the edge where the master samples ack
	assign access    = wb_cyc_i & wb_stb_i & wb_ack_o;
	assign wr_en     = access & wb_we_i & wb_sel_i[0];
	assign busy      = (state_reg != SPM_IDLE);
	assign start     = wr_en & (idx == `SPM_IDX_DATA3) & ~busy;
	assign half_cnt  = half_period(status_reg.shift_rate_sel);
	// Two edges per bit, 8 bits per length step
	assign last_edge = 7'((32'(control_reg.frame_length_sel) + 1) * 16 - 1);
	assign edge_tick = (state_reg == SPM_SHIFT) && (div_reg == '0);
	// Next edge is rising when the clock is currently low
	assign sample_edge = (~sclk_reg) ^ control_reg.clk_pha;
	assign rx_bit    = loopback_reg ? mosi_reg : serial_data_in;

	// Wishbone handshake: ack one cycle after the request, dropped after one cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	// Read data, registered with ack; unmapped reads return zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
			case (idx)
				`SPM_IDX_CONTROL: wb_dat_o <= {24'h00_0000, control_reg};
				`SPM_IDX_STATUS:  wb_dat_o <= {24'h00_0000, status_reg.irq_line_sel,
					status_reg.shift_rate_sel, status_reg.ext_irq_enable,
					status_reg.low_bit_first, ext_flag_reg, busy};
				`SPM_IDX_DATA0:   wb_dat_o <= {24'h00_0000, shift_reg[7:0]};
				`SPM_IDX_DATA1:   wb_dat_o <= {24'h00_0000, shift_reg[15:8]};
				`SPM_IDX_DATA2:   wb_dat_o <= {24'h00_0000, shift_reg[23:16]};
				`SPM_IDX_DATA3:   wb_dat_o <= {24'h00_0000, shift_reg[31:24]};
				`SPM_IDX_DEBUG:   wb_dat_o <= {30'h0000_0000, loopback_reg, 1'b0};
				default:          wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Control register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			control_reg <= spm_control_t'(`SPM_CONTROL_RST);
		end else if (wr_en && idx == `SPM_IDX_CONTROL) begin
			control_reg <= spm_control_t'(wr_byte);
		end
	end

	// Status register: only the writable upper six bits are stored
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			status_reg <= spm_status_t'(`SPM_STATUS_RST);
		end else if (wr_en && idx == `SPM_IDX_STATUS) begin
			status_reg.irq_line_sel   <= wr_byte[`SPM_STAT_IRQ_LINE_SEL_LSB +: 2];
			status_reg.shift_rate_sel <= wr_byte[`SPM_STAT_RATE_LSB +: 2];
			status_reg.ext_irq_enable <= wr_byte[`SPM_STAT_IRQEN_BIT];
			status_reg.low_bit_first  <= wr_byte[`SPM_STAT_LOWFST_BIT];
		end
	end

	// Debug register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			loopback_reg <= `SPM_DEBUG_RST == 8'h00 ? 1'b0 : 1'b1;
		end else if (wr_en && idx == `SPM_IDX_DEBUG) begin
			loopback_reg <= wr_byte[`SPM_DEBUG_LOOP_BIT];
		end
	end

	// External interrupt flag follows the pin, no latching
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_flag_reg <= 1'b0;
		end else begin
			ext_flag_reg <= ~ext_irq_in_n;
		end
	end

	// Host interrupt routing; held low while the input is not wired
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_reg <= 4'h0;
		end else if (EXT_IRQ_CONNECTED && status_reg.ext_irq_enable && ext_flag_reg) begin
			irq_reg <= 4'(4'h1 << status_reg.irq_line_sel);
		end else begin
			irq_reg <= 4'h0;
		end
	end
	assign host_irq_lines = irq_reg;

	// Sequencer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= SPM_IDLE;
		end else begin
			case (state_reg)
				SPM_IDLE:  if (start) state_reg <= SPM_SHIFT;
				SPM_SHIFT: if (edge_tick && edge_reg == last_edge) state_reg <= SPM_DONE;
				SPM_DONE:  state_reg <= SPM_IDLE;
				default:   state_reg <= SPM_IDLE;
			endcase
		end
	end

	// Rate divider and edge counter
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_reg  <= '0;
			edge_reg <= 7'h00;
		end else if (start) begin
			div_reg  <= half_cnt - CNT_W'(1);
			edge_reg <= 7'h00;
		end else if (state_reg == SPM_SHIFT) begin
			if (div_reg == '0) begin
				div_reg  <= half_cnt - CNT_W'(1);
				edge_reg <= edge_reg + 7'h01;
			end else begin
				div_reg <= div_reg - CNT_W'(1);
			end
		end
	end

	// Serial clock: parked at polarity, toggles on every divider tick
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclk_reg <= 1'b0;
		end else if (state_reg != SPM_SHIFT) begin
			sclk_reg <= control_reg.clk_pol;
		end else if (edge_tick) begin
			sclk_reg <= ~sclk_reg;
		end
	end

	// Data bytes double as the shift register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shift_reg <= `SPM_DATA_RST;
		end else if (edge_tick && sample_edge) begin
			if (status_reg.low_bit_first) begin
				shift_reg <= {rx_bit, shift_reg[31:1]};
			end else begin
				shift_reg <= {shift_reg[30:0], rx_bit};
			end
		end else if (wr_en && !busy) begin
			// Byte writes are refused mid-frame to keep the frame intact
			for (int b = 0; b < 4; b++) begin
				if (idx == 4'(`SPM_IDX_DATA0 + b)) begin
					shift_reg[b*8 +: 8] <= wr_byte;
				end
			end
		end
	end

	// Output bit: loaded at start, then updated only on drive edges after a sample
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mosi_reg    <= 1'b0;
			sampled_reg <= 1'b0;
		end else if (start) begin
			mosi_reg    <= status_reg.low_bit_first ? shift_reg[0] : wr_byte[7];
			sampled_reg <= 1'b0;
		end else if (edge_tick) begin
			if (sample_edge) begin
				sampled_reg <= 1'b1;
			end else if (sampled_reg) begin
				mosi_reg <= status_reg.low_bit_first ? shift_reg[0] : shift_reg[31];
			end
		end
	end

	// Slave selects: manual follows the field, auto only while shifting
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			select_reg <= 2'b00;
		end else if (control_reg.manual_select_mode) begin
			select_reg <= select_decode(control_reg.select_code);
		end else if (state_reg == SPM_SHIFT || start) begin
			select_reg <= select_decode(control_reg.select_code);
		end else begin
			select_reg <= 2'b00;
		end
	end

	always_comb begin
		serial_out.sclk                = sclk_reg;
		serial_out.mosi                = mosi_reg;
		serial_out.select_out_first_n  = ~select_reg[0];
		serial_out.select_out_second_n = ~select_reg[1];
	end

endmodule // spm_master

/* spm_pkg.sv */
// Types shared by the serial master: register layouts, states and pin bundle
package spm_pkg;

	typedef struct packed {
		logic       clk_pol;
		logic       clk_pha;
		logic [1:0] frame_length_sel;
		logic       manual_select_mode;
		logic [2:0] select_code;
	} spm_control_t;

	typedef struct packed {
		logic [1:0] irq_line_sel;
		logic [1:0] shift_rate_sel;
		logic       ext_irq_enable;
		logic       low_bit_first;
		logic       ext_irq_flag;
		logic       busy;
	} spm_status_t;

	typedef struct packed {
		logic       sclk;
		logic       mosi;
		logic       select_out_first_n;
		logic       select_out_second_n;
	} spm_serial_t;

	// Gray along idle -> shift -> done
	typedef enum logic [1:0] {
		SPM_IDLE  = 2'b00,
		SPM_SHIFT = 2'b01,
		SPM_DONE  = 2'b11
	} spm_state_t;

endpackage

/* spm_regs.svh */
// Register offsets, field positions, reset values and timing counts of the serial master
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// Register indices; byte address is four times the index
`define SPM_IDX_CONTROL   4'h8
`define SPM_IDX_STATUS    4'h9
`define SPM_IDX_DATA0     4'ha
`define SPM_IDX_DATA1     4'hb
`define SPM_IDX_DATA2     4'hc
`define SPM_IDX_DATA3     4'hd
`define SPM_IDX_DEBUG     4'he

// Control fields
`define SPM_CTRL_POL_BIT     7
`define SPM_CTRL_PHA_BIT     6
`define SPM_CTRL_LEN_LSB     4
`define SPM_CTRL_MAN_BIT     3
`define SPM_CTRL_SEL_LSB     0

// Status fields
`define SPM_STAT_IRQ_LINE_SEL_LSB  6
`define SPM_STAT_RATE_LSB    4
`define SPM_STAT_IRQEN_BIT   3
`define SPM_STAT_LOWFST_BIT  2
`define SPM_STAT_FLAG_BIT    1
`define SPM_STAT_BUSY_BIT    0

// Debug register field
`define SPM_DEBUG_LOOP_BIT   1

// Reset values
`define SPM_CONTROL_RST      8'h00
`define SPM_STATUS_RST       8'h00
`define SPM_DEBUG_RST        8'h00
`define SPM_DATA_RST         32'h0000_0000

// Timing: reference bus clock and logic clock, in kHz
`define SPM_REF_CLK_KHZ      33000
`define SPM_MCLK_KHZ         125000
`define SPM_SLOWEST_DIV      32

`endif

/* spm_slave_model.sv */
// Serial slave model: records sampled bits and answers with a given word
`timescale 1ns/100ps
module spm_slave_model (
	// Clock and pins
	input wire logic        mclk,
	input wire logic        sclk,
	input wire logic        mosi,
	input wire logic        sel_n,
	// Mode and reply word
	input wire logic        pol,
	input wire logic        pha,
	input wire logic [31:0] pat,
	output logic            miso,
	output logic [31:0]     rx
);
	int   k = 0;
	logic tog = 1'b0;
	always @(posedge mclk) tog <= ~tog;
	// Leading edge only drives when it does not sample
	always @(negedge sel_n) k = (pol == pha) ? 0 : -1;
	always @(sclk) begin
		if (!sel_n && sclk == !pha) rx = {rx[30:0], mosi};
		else if (!sel_n) k++;
	end
	// Deselected line floats, so show a changing level
	assign miso = (sel_n || k < 0 || k > 31) ? tog : pat[31-k];
endmodule // spm_slave_model

/* tb_spi_master_port.sv */
// Random and corner-case frames against the serial master and a slave model
`timescale 1ns/100ps
`include "spm_regs.svh"
module tb_spi_master_port;
	import spm_pkg::*;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic [5:0]  adr = '0;
	logic [31:0] wdat = '0;
	logic [3:0]  sel = '0;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        irq_n = 1'b1;
	logic        pol = 1'b0;
	logic        pha = 1'b0;
	logic [31:0] pat = '0;
	logic [31:0] rdat;
	logic        ack;
	logic        miso;
	logic [31:0] rx;
	logic [3:0]  hirq;
	logic [7:0]  q;
	spm_serial_t so;
	int          bad_count = 0;
	int          check_count = 0;
	wire         sel_n = so.select_out_first_n & so.select_out_second_n;

	spm_master u_spm_master (.mclk(mclk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .serial_out(so), .serial_data_in(miso), .ext_irq_in_n(irq_n),
		.host_irq_lines(hirq));
	spm_slave_model u_spm_slave_model (.mclk(mclk), .sclk(so.sclk), .mosi(so.mosi),
		.sel_n(sel_n), .pol(pol), .pha(pha), .pat(pat), .miso(miso), .rx(rx));

	initial forever #4 mclk = ~mclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, idx, 2'b00, 24'h0, d, 4'hf};
		// Ack and read data are taken on the rising edge where the write lands
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (n >= 100) begin
			$display("[FAIL] %0t ack %h exp %h", $time, ack, 1'b1);
			bad_count++;
		end
		r = rdat[7:0];
		{cyc, stb} <= 2'b00;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Bits the master keeps and the slave records after n shifts
	function automatic void expect_f(input logic [31:0] d, p, input int n,
		input logic lsb, lb, output logic [31:0] me, mk, se);
		logic s;
		int   j;
		me = '0;
		mk = '0;
		se = '0;
		for (int k = 0; k < n; k++) begin
			s = lsb ? d[k] : d[31-k];
			j = lsb ? 32 - n + k : n - 1 - k;
			se[n-1-k] = s;
			me[j] = lb ? s : p[31-k];
			mk[j] = 1'b1;
		end
	endfunction

	task automatic frame(input logic [1:0] len, input logic [1:0] rate, input logic [4:0] r);
		logic [31:0] d, me, mk, se, got;
		int          n, h, c;
		d = $urandom();
		pat = $urandom();
		n = 8 * (len + 1);
		h = rate == 0 ? 60 : rate == 1 ? 30 : rate == 2 ? 15 : 7;
		pol = r[0];
		pha = r[1];
		@(posedge mclk);
		irq_n <= 1'($urandom());
		bus(1, `SPM_IDX_CONTROL, {r[0], r[1], len, 2'b00, r[4], ~r[4]}, q);
		bus(1, `SPM_IDX_STATUS, {len ^ rate, rate, r[4], r[2], 2'b00}, q);
		bus(1, `SPM_IDX_DEBUG, {6'h0, r[3], 1'b0}, q);
		chk(so.sclk, r[0]);
		bus(0, `SPM_IDX_STATUS, 8'h00, q);
		chk(q[7:2], {len ^ rate, rate, r[4], r[2]});
		chk(q[1], {~irq_n});
		chk(hirq, 4'h0);
		for (int i = 0; i < 4; i++) bus(1, 4'(`SPM_IDX_DATA0 + i), d[8*i +: 8], q);
		repeat (2) @(negedge mclk);
		chk({so.select_out_second_n, so.select_out_first_n}, {~r[4], r[4]});
		c = 0;
		while (so.sclk === r[0] && c < 200) begin
			@(negedge mclk);
			c++;
		end
		c = 0;
		while (so.sclk !== r[0] && c < 200) begin
			@(negedge mclk);
			c++;
		end
		chk(c, h);
		bus(1, `SPM_IDX_DATA0, ~d[7:0], q);
		bus(0, `SPM_IDX_STATUS, 8'h00, q);
		chk(q[0], 1'b1);
		c = 0;
		while (q[0] !== 1'b0 && c < 3000) begin
			bus(0, `SPM_IDX_STATUS, 8'h00, q);
			c++;
		end
		chk(sel_n, 1'b1);
		chk(so.sclk, r[0]);
		for (int i = 0; i < 4; i++) begin
			bus(0, 4'(`SPM_IDX_DATA0 + i), 8'h00, q);
			got[8*i +: 8] = q;
		end
		expect_f(d, pat, n, r[2], r[3], me, mk, se);
		chk(got & mk, me);
		chk(rx & (32'hffff_ffff >> (32 - n)), se);
	endtask

	initial begin
		void'($urandom(41389));
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		bus(0, `SPM_IDX_CONTROL, 8'h00, q);
		chk(q, `SPM_CONTROL_RST);
		bus(0, `SPM_IDX_STATUS, 8'h00, q);
		chk(q, `SPM_STATUS_RST);
		bus(1, 4'hf, 8'h5a, q);
		bus(0, 4'hf, 8'h00, q);
		chk(q, 8'h00);
		for (int s = 0; s < 8; s++) begin
			bus(1, `SPM_IDX_CONTROL, 8'(8 + s), q);
			repeat (2) @(negedge mclk);
			chk({so.select_out_second_n, so.select_out_first_n},
				s == 1 ? 2'b10 : s == 2 ? 2'b01 : 2'b11);
		end
		// First four frames walk every length and rate
		for (int i = 0; i < 10; i++)
			frame(i < 4 ? 2'(i) : 2'($urandom()), i < 4 ? 2'(3 - i) : 2'($urandom()),
				5'($urandom()) & {1'b1, i > 3, 3'h7});
		final_report();
	end

	initial begin
		repeat (90000) @(posedge mclk);
		bad_count++;
		final_report();
	end
endmodule // tb_spi_master_port
